// ==== rtl/edm_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module edm_top
  import edm_pkg::*;
#(
  parameter int CH = 0,
  parameter int TW = 24,
  parameter int CW = 32
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_c,
  input wire logic latch_in,
  input wire logic gate_in,
  input wire logic [CW-1:0] count_in,
  input wire logic [`EDM_TS_BITS-1:0] dc_time,
  input wire logic cycle_strobe,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_code,
  input wire logic [1:0] eval_mode,
  input wire logic micro_en,
  input wire logic compact_ts,
  input wire logic latch_c_en,
  input wire logic latch_rise_en,
  input wire logic latch_fall_en,
  input wire logic latch2_rise_en,
  input wire logic latch2_fall_en,
  output logic [15:0] duty_ratio_value,
  output logic [15:0] duty_ratio_lowest,
  output logic [15:0] duty_ratio_highest,
  output logic [CW-1:0] count_report,
  output logic interp_stall,
  output logic [`EDM_TS_BITS-1:0] ts_count,
  output logic [`EDM_TS_BITS-1:0] ts_zero,
  output logic [`EDM_TS_BITS-1:0] ts_latch,
  output logic [`EDM_TS_BITS-1:0] ts_latch2,
  output logic [CW-1:0] latch_value,
  output logic [CW-1:0] latch2_value
);

  localparam int HW = TW + 1;
  localparam int NW = TW + `EDM_DUTY_SCALE_BITS;
  localparam logic [HW-1:0] HMAX = '1;
  localparam logic [15:0] CLR_MIN_CODE = (CH == 0) ? `EDM_CMD_MIN_CH1 : `EDM_CMD_MIN_CH2;
  localparam logic [15:0] CLR_MAX_CODE = (CH == 0) ? `EDM_CMD_MAX_CH1 : `EDM_CMD_MAX_CH2;

  // Previous input levels for edge detection: gate, latch, C, B, A
  logic [4:0] prev_lvl;

  wire a_rise = edm_rise(enc_a, prev_lvl[0]);
  wire a_fall = edm_fall(enc_a, prev_lvl[0]);
  wire b_any = edm_rise(enc_b, prev_lvl[1]) | edm_fall(enc_b, prev_lvl[1]);
  wire c_rise = edm_rise(enc_c, prev_lvl[2]);
  wire l_rise = edm_rise(latch_in, prev_lvl[3]);
  wire l_fall = edm_fall(latch_in, prev_lvl[3]);
  wire g_rise = edm_rise(gate_in, prev_lvl[4]);
  wire g_fall = edm_fall(gate_in, prev_lvl[4]);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_lvl <= '0;
    end else begin
      prev_lvl <= {gate_in, latch_in, enc_c, enc_b, enc_a};
    end
  end

  // Track A timing. The timer runs in 5 ns units because 25 ns is not a
  // whole multiple of 10 ns; dropping its low bit gives 10 ns resolution.
  logic [HW-1:0] since_rise;
  logic rise_seen;
  logic fall_seen;
  logic [TW-1:0] ton_hold;
  logic [TW-1:0] period_q;
  logic period_ok;

  wire [HW:0] since_next = {1'b0, since_rise} + (HW+1)'(`EDM_TB_STEP);
  wire overlong = (since_rise == HMAX);
  wire [TW-1:0] since_10ns = since_rise[HW-1:1];
  wire period_done = a_rise && rise_seen && fall_seen && !overlong;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      since_rise <= '0;
      rise_seen <= 1'b0;
      fall_seen <= 1'b0;
      ton_hold <= '0;
      period_q <= '0;
      period_ok <= 1'b0;
    end else begin
      // 5 ns time base, read out at 10 ns
      // The rise sample already closes one clock of the new interval
      if (a_rise) begin
        since_rise <= HW'(`EDM_TB_STEP);
      end else if (!since_next[HW]) begin
        since_rise <= since_next[HW-1:0];
      end else begin
        since_rise <= HMAX;
      end
      if (a_rise) begin
        rise_seen <= 1'b1;
        fall_seen <= 1'b0;
        period_q <= since_10ns;
        period_ok <= rise_seen && !overlong;
      end else if (overlong) begin
        period_ok <= 1'b0;
      end
      // high time up to falling edge
      if (a_fall && rise_seen && !fall_seen) begin
        ton_hold <= since_10ns;
        fall_seen <= 1'b1;
      end
    end
  end

  // Completed periods queue for the divider; a newer one replaces any waiting
  logic pend;
  logic [TW-1:0] pend_ton;
  logic [TW-1:0] pend_per;
  logic div_busy;
  logic div_done;
  logic [NW-1:0] div_quot;

  wire div_start = pend && !div_busy;
  // high time times 10000 over period
  wire [NW-1:0] div_num = NW'(pend_ton) * NW'(`EDM_DUTY_FULL);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend <= 1'b0;
      pend_ton <= '0;
      pend_per <= '0;
    end else begin
      if (div_start) begin
        pend <= 1'b0;
      end
      if (period_done) begin
        pend <= 1'b1;
        pend_ton <= ton_hold;
        pend_per <= since_10ns;
      end
    end
  end

  edm_divider #(
    .NW(NW),
    .DW(TW)
  ) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .start(div_start),
    .num(div_num),
    .den(pend_per),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot)
  );

  // Rounding of the divider can never exceed full scale, but clamp anyway
  wire quot_over = (|div_quot[NW-1:16]) || (div_quot[15:0] > `EDM_DUTY_FULL);
  wire [15:0] quot_clamped = quot_over ? `EDM_DUTY_FULL : div_quot[15:0];

  logic [15:0] last_duty;
  logic fresh;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_duty <= `EDM_DUTY_RST;
      fresh <= 1'b0;
    end else begin
      if (cycle_strobe) begin
        fresh <= 1'b0;
      end
      if (div_done) begin
        last_duty <= quot_clamped;
        fresh <= 1'b1;
      end
    end
  end

  // Publish and extremes. A clear of the highest and a publish in the same cycle
  // leave the new value in play; a clear of the lowest loads 0 regardless.
  // last period of the cycle
  wire publish = cycle_strobe && fresh;
  wire clr_min = cmd_valid && (cmd_code == CLR_MIN_CODE);
  wire clr_max = cmd_valid && (cmd_code == CLR_MAX_CODE);
  wire [15:0] min_base = clr_min ? 16'h0000 : duty_ratio_lowest;
  wire [15:0] max_base = clr_max ? 16'h0000 : duty_ratio_highest;
  wire [15:0] next_min = (publish && (last_duty < min_base)) ? last_duty : min_base;
  wire [15:0] next_max = (publish && (last_duty > max_base)) ? last_duty : max_base;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      duty_ratio_value <= `EDM_DUTY_RST;
      duty_ratio_lowest <= `EDM_MIN_RST;
      duty_ratio_highest <= `EDM_MAX_RST;
    end else begin
      if (publish) begin
        duty_ratio_value <= last_duty;
      end
      duty_ratio_lowest <= next_min;
      duty_ratio_highest <= next_max;
    end
  end

  // Counting edges per evaluation setting
  logic count_edge;
  logic [2:0] epp;

  always_comb begin
    case (edm_eval_t'(eval_mode))
      EDM_EVAL_X1: begin
        count_edge = a_rise;
        epp = `EDM_EPP_X1;
      end
      EDM_EVAL_X2: begin
        count_edge = a_rise | a_fall;
        epp = `EDM_EPP_X2;
      end
      default: begin
        count_edge = a_rise | a_fall | b_any;
        epp = `EDM_EPP_X4;
      end
    endcase
  end

  logic [`EDM_SUB_BITS-1:0] sub;
  logic stall;

  edm_microinc #(
    .TW(TW)
  ) u_micro (
    .core_clk(core_clk),
    .rst(rst),
    .count_edge(count_edge),
    .period(period_q),
    .period_ok(period_ok),
    .epp(epp),
    .sub(sub),
    .stall(stall)
  );

  wire [`EDM_SUB_BITS-1:0] sub_shown = stall ? '0 : sub;
  wire [CW-1:0] count_shown = micro_en ? {count_in[CW-`EDM_SUB_BITS-1:0], sub_shown} : count_in;

  logic [`EDM_TS_BITS-1:0] ts_edge_hold;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ts_edge_hold <= '0;
      count_report <= '0;
      interp_stall <= 1'b0;
      ts_count <= '0;
    end else begin
      if (count_edge) begin
        ts_edge_hold <= dc_time;
      end
      if (cycle_strobe) begin
        count_report <= count_shown;
        interp_stall <= stall;
        ts_count <= edm_ts_fit(ts_edge_hold, compact_ts);
      end
    end
  end

  // Captures. Zero pulse and external input share one capture value; if both
  // fire in one cycle the external input's count is kept.
  wire cap_c = latch_c_en && c_rise;
  wire cap_l = (latch_rise_en && l_rise) || (latch_fall_en && l_fall);
  wire cap_g = (latch2_rise_en && g_rise) || (latch2_fall_en && g_fall);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      latch_value <= '0;
      latch2_value <= '0;
      ts_zero <= '0;
      ts_latch <= '0;
      ts_latch2 <= '0;
    end else begin
      if (cap_c) begin
        latch_value <= count_shown;
        ts_zero <= edm_ts_fit(dc_time, compact_ts);
      end
      if (cap_l) begin
        latch_value <= count_shown;
        ts_latch <= edm_ts_fit(dc_time, compact_ts);
      end
      if (cap_g) begin
        latch2_value <= count_shown;
        ts_latch2 <= edm_ts_fit(dc_time, compact_ts);
      end
    end
  end

endmodule

`default_nettype wire

// ==== include/edm_defs.svh ====
`ifndef EDM_DEFS_SVH
`define EDM_DEFS_SVH

// Time base
`define EDM_TB_RES_NS 10
`define EDM_CLK_NS 25
// Timer steps in half-resolution units (5 ns) per core clock
`define EDM_TB_STEP ((2 * `EDM_CLK_NS) / `EDM_TB_RES_NS)

// Interpolation stall limit
`define EDM_STALL_NS 1340
`define EDM_STALL_UNITS (`EDM_STALL_NS / `EDM_TB_RES_NS)

// Duty ratio scale and reset values
`define EDM_DUTY_FULL 16'h2710
`define EDM_DUTY_RST 16'h0000
`define EDM_MIN_RST 16'h2710
`define EDM_MAX_RST 16'h0000
`define EDM_DUTY_SCALE_BITS 14

// Command object request codes
`define EDM_CMD_MIN_CH1 16'h9130
`define EDM_CMD_MAX_CH1 16'h9140
`define EDM_CMD_MIN_CH2 16'h9131
`define EDM_CMD_MAX_CH2 16'h9141

// Micro-increments
`define EDM_SUB_BITS 8
`define EDM_SUB_STEPS 256
`define EDM_EPP_X4 3'h4
`define EDM_EPP_X2 3'h2
`define EDM_EPP_X1 3'h1

// Timestamps
`define EDM_TS_BITS 64
`define EDM_TS_COMPACT_MASK 64'h0000_0000_FFFF_FFFF

`endif

// ==== include/edm_pkg.sv ====
`include "edm_defs.svh"

package edm_pkg;

  typedef enum logic [1:0] {
    EDM_EVAL_X4,
    EDM_EVAL_X1,
    EDM_EVAL_X2
  } edm_eval_t;

  typedef enum logic {
    EDM_DIV_IDLE,
    EDM_DIV_RUN
  } edm_div_state_t;

  function automatic logic edm_rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  function automatic logic edm_fall(input logic now, input logic prev);
    return ~now & prev;
  endfunction

  function automatic logic [`EDM_TS_BITS-1:0] edm_ts_fit(input logic [`EDM_TS_BITS-1:0] t,
                                                       input logic compact);
    return compact ? (t & `EDM_TS_COMPACT_MASK) : t;
  endfunction

endpackage

// ==== rtl/edm_divider.sv ====
`timescale 1ns/1ps
`default_nettype none

module edm_divider
  import edm_pkg::*;
#(
  parameter int NW = 38,
  parameter int DW = 24
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic busy,
  output logic done,
  output logic [NW-1:0] quot
);

  edm_div_state_t state;
  logic [NW-1:0] n;
  logic [DW-1:0] d;
  logic [DW-1:0] r;
  logic [$clog2(NW+1)-1:0] cnt;

  // Restoring division, one quotient bit per clock; a zero divisor yields all ones only when num fits in DW bits
  wire [DW:0] shifted = {r, n[NW-1]};
  wire [DW:0] diff = shifted - {1'b0, d};
  wire fits = ~diff[DW];
  wire last_step = (cnt == ($clog2(NW+1))'(1));

  assign busy = (state == EDM_DIV_RUN);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= EDM_DIV_IDLE;
      n <= '0;
      d <= '0;
      r <= '0;
      cnt <= '0;
      done <= 1'b0;
      quot <= '0;
    end else begin
      done <= 1'b0;
      case (state)
        EDM_DIV_IDLE: begin
          if (start) begin
            n <= num;
            d <= den;
            r <= '0;
            cnt <= ($clog2(NW+1))'(NW);
            state <= EDM_DIV_RUN;
          end
        end
        EDM_DIV_RUN: begin
          r <= fits ? diff[DW-1:0] : shifted[DW-1:0];
          n <= {n[NW-2:0], fits};
          cnt <= cnt - ($clog2(NW+1))'(1);
          if (last_step) begin
            quot <= {n[NW-2:0], fits};
            done <= 1'b1;
            state <= EDM_DIV_IDLE;
          end
        end
        default: state <= EDM_DIV_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== rtl/edm_microinc.sv ====
`timescale 1ns/1ps
`default_nettype none

module edm_microinc
  import edm_pkg::*;
#(
  parameter int TW = 24
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic count_edge,
  input wire logic [TW-1:0] period,
  input wire logic period_ok,
  input wire logic [2:0] epp,
  output logic [`EDM_SUB_BITS-1:0] sub,
  output logic stall
);

  localparam int AW = TW + 16;
  localparam logic [`EDM_SUB_BITS-1:0] SUB_MAX = '1;

  logic [AW-1:0] acc;

  // Phase advances by elapsed time times 256 edges-per-period; one sub-step
  // each time it passes the period (both in 5 ns units)
  wire [AW-1:0] step = AW'(`EDM_TB_STEP) * AW'(`EDM_SUB_STEPS) * AW'(epp);
  wire [AW-1:0] thresh = AW'({period, 1'b0});
  wire [AW-1:0] acc_next = acc + step;
  wire crossed = period_ok && (acc_next >= thresh);
  wire room = (sub != SUB_MAX);

  always_ff @(posedge core_clk) begin
    if (rst || count_edge) begin
      acc <= '0;
      sub <= '0;
    end else if (crossed && room) begin
      acc <= acc_next - thresh;
      sub <= sub + `EDM_SUB_BITS'(1);
    end else if (period_ok && room) begin
      acc <= acc_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stall <= 1'b0;
    end else begin
      stall <= period_ok && (period <= TW'(`EDM_STALL_UNITS));
    end
  end

endmodule

`default_nettype wire

// ==== testbench/edm_top_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module edm_top_checker
  import edm_pkg::*;
#(
  parameter int CH = 0,
  parameter int CW = 32
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enc_c,
  input wire logic latch_in,
  input wire logic [CW-1:0] count_in,
  input wire logic [63:0] dc_time,
  input wire logic cycle_strobe,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_code,
  input wire logic micro_en,
  input wire logic compact_ts,
  input wire logic latch_c_en,
  input wire logic latch_rise_en,
  input wire logic [15:0] duty_ratio_value,
  input wire logic [15:0] duty_ratio_lowest,
  input wire logic [15:0] duty_ratio_highest,
  input wire logic [CW-1:0] count_report,
  input wire logic interp_stall,
  input wire logic [63:0] ts_count,
  input wire logic [63:0] ts_zero,
  input wire logic [63:0] ts_latch
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire [15:0] min_code = (CH != 0) ? 16'h9131 : 16'h9130;
  wire [15:0] max_code = (CH != 0) ? 16'h9141 : 16'h9140;
  chk_lowest_start:
    assert property (disable iff (1'b0) rst |=> duty_ratio_lowest == 16'h2710)
    else $error("lowest not at start value");
  chk_highest_start:
    assert property (disable iff (1'b0) rst |=> duty_ratio_highest == 16'h0000)
    else $error("highest not at start value");
  chk_min_clear:
    assert property (cmd_valid && cmd_code == min_code |=> duty_ratio_lowest == 16'h0000)
    else $error("lowest not cleared");
  // A publish in the same cycle may legally set a new maximum
  chk_max_clear:
    assert property (cmd_valid && cmd_code == max_code && !cycle_strobe
                     |=> duty_ratio_highest == 16'h0000)
    else $error("highest not cleared");
  chk_bounds_track:
    assert property ($changed(duty_ratio_value) && !$past(rst) |-> duty_ratio_lowest
                     <= duty_ratio_value && duty_ratio_value <= duty_ratio_highest)
    else $error("lowest or highest not tracking value");
  chk_full_scale:
    assert property (duty_ratio_value <= 16'h2710 && duty_ratio_highest <= 16'h2710)
    else $error("duty ratio above full scale");
  chk_count_plain:
    assert property (cycle_strobe && !micro_en |=> count_report == $past(count_in))
    else $error("count altered without interpolation");
  chk_count_shift:
    assert property (cycle_strobe && micro_en
                     |=> count_report[CW-1:8] == $past(count_in[CW-9:0]))
    else $error("count not above sub bits");
  chk_stall_zero:
    assert property (cycle_strobe && micro_en ##1 interp_stall |-> count_report[7:0] == 8'h00)
    else $error("sub bits not zero in stall");
  chk_compact_ts:
    assert property (cycle_strobe && compact_ts |=> ts_count[63:32] == 32'h0000_0000)
    else $error("compact stamp has upper bits");
  chk_zero_stamp:
    assert property (latch_c_en && enc_c && !$past(enc_c)
                     |=> ts_zero[31:0] == $past(dc_time[31:0]))
    else $error("zero pulse stamp wrong");
  chk_latch_stamp:
    assert property (latch_rise_en && latch_in && !$past(latch_in)
                     |=> ts_latch[31:0] == $past(dc_time[31:0]))
    else $error("latch stamp wrong");
  cover property ($changed(duty_ratio_value));
  cover property (interp_stall);
  cover property (cmd_valid && cmd_code == min_code);
endmodule
bind edm_top edm_top_checker #(.CH(CH), .CW(CW)) u_chk (.*);
`default_nettype wire

// ==== testbench/edm_enc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module edm_enc_model (
  input wire logic core_clk,
  input wire logic run,
  input wire logic [7:0] hi,
  input wire logic [7:0] per,
  output logic a,
  output logic b,
  output logic c
);
  logic [7:0] ph;
  wire [7:0] q = per >> 2;
  // Tracks park low while stopped, like an encoder at rest
  always_ff @(posedge core_clk) begin
    ph <= (!run || ph >= per - 8'h01) ? 8'h00 : ph + 8'h01;
  end
  assign a = run && ph < hi;
  assign b = run && ph >= q && ph < hi + q;
  assign c = run && ph < 8'h02;
endmodule
`default_nettype wire

// ==== testbench/tb_encoder_duty_microinc_timestamp.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_encoder_duty_microinc_timestamp;
  import edm_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, run = 1'b0, enc_a, enc_b, enc_c;
  logic [7:0] hi = 8'h28, per = 8'h50;
  logic latch_in = 1'b0, gate_in = 1'b0, cycle_strobe = 1'b0, cmd_valid = 1'b0;
  logic micro_en = 1'b0, compact_ts = 1'b0, latch_c_en = 1'b0, latch_rise_en = 1'b1;
  logic latch_fall_en = 1'b0, latch2_rise_en = 1'b0, latch2_fall_en = 1'b1;
  logic [31:0] count_in = 32'h1234_5678, count_report, latch_value, latch2_value;
  logic [63:0] dc_time = 64'hABCD_0000_0000_0000, ts_count, ts_zero, ts_latch, ts_latch2;
  logic [15:0] cmd_code = 16'h0000, duty_ratio_value, duty_ratio_lowest, duty_ratio_highest;
  logic [1:0] eval_mode = 2'h0;
  logic interp_stall;
  int n_errors = 0, comparisons = 0;
  always #12.5 core_clk = ~core_clk;
  // Free-running system time, one tick per clock
  always @(posedge core_clk) dc_time <= dc_time + 64'h1;
  edm_top #(.CH(0)) dut_u (.*);
  edm_enc_model enc_u (.core_clk, .run, .hi, .per, .a(enc_a), .b(enc_b), .c(enc_c));
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic strobe();
    tick(1);
    cycle_strobe <= 1'b1;
    tick(1);
    cycle_strobe <= 1'b0;
    tick(1);
    #1;
  endtask
  task automatic cmd(input logic [15:0] code);
    tick(1);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    tick(1);
    cmd_valid <= 1'b0;
    tick(1);
    #1;
  endtask
  task automatic wait_lvl(input logic v);
    int k;
    k = 0;
    while (enc_a !== v) begin
      tick(1);
      k++;
      if (k > 400) begin
        n_errors++;
        complete_run();
      end
    end
  endtask
  task automatic t_reset();
    chk("value", duty_ratio_value, 64'h0);
    chk("lowest", duty_ratio_lowest, 64'h2710);
    chk("highest", duty_ratio_highest, 64'h0);
  endtask
  task automatic t_duty();
    tick(1);
    run <= 1'b1;
    latch_c_en <= 1'b1;
    tick(320);
    strobe();
    chk("duty", duty_ratio_value, 64'h1388);
    chk("highest", duty_ratio_highest, 64'h1388);
    // Odd cycle counts tell a 10 ns base from a raw clock count
    tick(1);
    hi <= 8'h0D;
    per <= 8'h51;
    tick(320);
    strobe();
    chk("duty", duty_ratio_value, 64'h630);
    chk("lowest", duty_ratio_lowest, 64'h630);
    chk("highest", duty_ratio_highest, 64'h1388);
  endtask
  task automatic t_clear();
    cmd(16'h9131);
    cmd(16'h9141);
    chk("lowest", duty_ratio_lowest, 64'h630);
    chk("highest", duty_ratio_highest, 64'h1388);
    cmd(16'h9140);
    chk("highest", duty_ratio_highest, 64'h0);
    cmd(16'h9130);
    chk("lowest", duty_ratio_lowest, 64'h0);
  endtask
  task automatic t_stall(input logic [7:0] p, input logic exp);
    tick(1);
    per <= p;
    hi <= 8'h10;
    tick(300);
    strobe();
    chk("stall", interp_stall, exp);
    chk("count high", count_report[31:8], 64'h345678);
    if (exp) chk("sub bits", count_report[7:0], 64'h0);
  endtask
  task automatic t_micro();
    tick(1);
    micro_en <= 1'b1;
    t_stall(8'h36, 1'b0);
    t_stall(8'h35, 1'b1);
    tick(1);
    micro_en <= 1'b0;
    strobe();
    chk("count", count_report, 64'h1234_5678);
  endtask
  task automatic t_eval();
    logic [63:0] d [3];
    tick(1);
    hi <= 8'h28;
    per <= 8'h50;
    for (int m = 0; m < 3; m++) begin
      tick(1);
      eval_mode <= m[1:0];
      tick(200);
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      // Strobe at a fixed phase, as a synchronous master samples
      tick(69);
      d[m] = dc_time;
      strobe();
      d[m] = d[m] - ts_count;
    end
    chk("edge gap", d[1] - d[2], 64'h28);
    chk("edge gap", d[2] - d[0], 64'h14);
  endtask
  task automatic t_cap();
    logic [63:0] e;
    tick(1);
    run <= 1'b0;
    count_in <= 32'h0000_0ABC;
    for (int c = 0; c < 2; c++) begin
      tick(1);
      compact_ts <= c[0];
      tick(1);
      latch_in <= 1'b1;
      e = dc_time + 64'h1;
      tick(3);
      latch_in <= 1'b0;
      #1;
      chk("latch ts", ts_latch, (c != 0) ? e & 64'hFFFF_FFFF : e);
      chk("latch value", latch_value, 64'hABC);
      if (c != 0) begin
        strobe();
        chk("count ts high", ts_count[63:32], 64'h0);
      end
    end
    tick(1);
    compact_ts <= 1'b0;
    gate_in <= 1'b1;
    tick(3);
    #1;
    chk("gate rise", ts_latch2, 64'h0);
    tick(1);
    gate_in <= 1'b0;
    e = dc_time + 64'h1;
    tick(2);
    #1;
    chk("gate ts", ts_latch2, e);
    chk("gate value", latch2_value, 64'hABC);
  endtask
  initial begin
    tick(2);
    rst <= 1'b0;
    tick(1);
    #1;
    t_reset();
    t_duty();
    t_clear();
    t_micro();
    t_eval();
    t_cap();
    complete_run();
  end
endmodule
`default_nettype wire
